// >>> cfg_host_model.sv
// host side model issuing one-cycle configuration accesses
// assumes the bank answers with a one-cycle ack one clock after the strobe
`timescale 1ns/1ps
`default_nettype none
module cfg_host_model (
  input  wire logic                    i_core_clk,
  input  wire logic                    i_ack,
  input  wire logic [31:0]             i_rdata,
  output var logic                     o_valid,
  output var pci_cfg_pkg::cfg_req_type o_req
);
  logic        ack_seen;
  logic [31:0] rd_q;

  // bus idles with strobe low
  initial
  begin
    o_valid = 1'b0;
    o_req   = '0;
  end

  // strobe one cycle, then take ack and data in the answer cycle
  task automatic access(input logic wr, input logic [7:0] a,
                        input logic [3:0] be, input logic [31:0] d);
    @(posedge i_core_clk);
    o_valid <= 1'b1;
    o_req   <= {wr, a, be, d};
    @(posedge i_core_clk);
    o_valid <= 1'b0;
    // released bus carries inverted data so nothing stale can match
    o_req   <= {1'b0, ~a, 4'h0, ~d};
    #1;
    ack_seen = i_ack;
    rd_q     = i_rdata;
  endtask : access
endmodule : cfg_host_model
`default_nettype wire

// >>> pci_cfg_pkg.sv
// constants, field layouts and carrier types of the configuration register bank
// assumes one core clock domain; offsets are configuration byte addresses
package pci_cfg_pkg;

  // register byte offsets
  localparam logic [7:0] OFS_CLASS   = 8'h08;
  localparam logic [7:0] OFS_LAT     = 8'h0c;
  localparam logic [7:0] OFS_IO      = 8'h10;
  localparam logic [7:0] OFS_MEM     = 8'h14;
  localparam logic [7:0] OFS_CIS     = 8'h28;
  localparam logic [7:0] OFS_SUBSYS  = 8'h2c;
  localparam logic [7:0] OFS_ROM     = 8'h30;
  localparam logic [7:0] OFS_CAPHEAD = 8'h34;
  localparam logic [7:0] OFS_IRQ     = 8'h3c;
  localparam logic [7:0] OFS_SCRATCH = 8'h40;
  localparam logic [7:0] OFS_SIG     = 8'h80;
  localparam logic [7:0] OFS_PMCAP   = 8'hc0;
  localparam logic [7:0] OFS_PMCSR   = 8'hc4;

  // writable bit masks per register
  localparam logic [31:0] LAT_WR_MASK     = 32'h0000_ffff;
  localparam logic [31:0] IO_WR_MASK      = 32'hffff_ff00;
  localparam logic [31:0] MEM_WR_MASK     = 32'hffff_fc00;
  localparam logic [31:0] ROM_WR_MASK     = 32'hfffe_0001;
  localparam logic [31:0] IRQ_WR_MASK     = 32'h0000_00ff;
  localparam logic [31:0] SCRATCH_WR_MASK = 32'h0000_ff00;
  localparam logic [31:0] PMCSR_WR_MASK   = 32'h0000_1f03;

  // field positions
  localparam int IO_ADDR_LSB     = 8;
  localparam int MEM_ADDR_LSB    = 10;
  localparam int ROM_ADDR_LSB    = 17;
  localparam int WAKE_STATUS_BIT = 15;
  localparam int WAKE_EN_BIT     = 8;
  localparam int DATA_REPORT_SELECT_LSB        = 9;

  // fixed values and reset values
  localparam logic [31:0] IO_RESET       = 32'h0000_0001;
  localparam logic [7:0]  CAP_HEAD_PTR   = 8'hc0;
  localparam logic [7:0]  IRQ_PIN_CODE   = 8'h01;
  localparam logic [31:0] PM_CAP_WORD    = 32'hfe82_0001;
  localparam logic [1:0]  PSTATE_D0      = 2'b00;
  localparam logic [1:0]  DATA_SCALE_NONE = 2'b00;

  // eeprom reload sequencing, gray along idle-request-wait
  typedef enum logic [1:0] {
    LD_IDLE = 2'b00,
    LD_REQ  = 2'b01,
    LD_WAIT = 2'b11
  } load_state_type;

  // one configuration access
  typedef struct packed {
    logic        wr;
    logic [7:0]  addr;
    logic [3:0]  be;
    logic [31:0] wdata;
  } cfg_req_type;

  // values delivered by the serial eeprom engine
  typedef struct packed {
    logic [15:0] subsys_id_field;
    logic [15:0] subsys_vendor_field;
    logic [7:0]  max_latency_need;
    logic [7:0]  min_grant_need;
    logic [31:0] card_info;
  } eeprom_image_type;

endpackage : pci_cfg_pkg

// >>> pci_config_space_regs.sv
// configuration-space register bank: identification, windows, timing,
// interrupt routing, scratch, signature and power management
// assumes the pci target decodes cycles into one-cycle cfg requests on
// the core clock; frame and grant pins are asynchronous and synchronised
//
// Function
// - latency counts from frame; expiry without grant ends tenure
// - io base keeps bits 31:8, reserved 7:1, bit 0 reads one
// - memory base keeps bits 31:10, bits 9:0 read zero
// - rom decodes only with rom enable and memory space enable
// - writing all ones to rom base reads back fffe0001
// - max latency and min grant read-only, loaded from eeprom
// - interrupt pin field always reads 01h
// - scratch byte 15:8 read-write, cleared by reset, rest zero
// - subsystem ids read-only and loaded from eeprom
// - signature is a hard-wired read-only constant
// - class code register read-only with class, subclass, revision, step
// - power capability reads id 01h, next pointer 0, version 010b
// - capability reports d1, d2 and wake from d0 to d3
// - wake status sets on events; write one clears; set wins
// - wake pin driven only when wake enable is one
// - both command wake bits set enable wake packet by default
// - power state field read-write, forced to d0 on power resume
// - data select writable without effect, data scale reads zero
// - card info read-only, reloaded from eeprom after pci reset
// - capabilities pointer reads c0h, upper bits zero
// - memory space enable is command bit 1, supplied as input

`timescale 1ns/1ps
`default_nettype none

module pci_config_space_regs #(
  parameter logic [7:0]  BASE_CLASS  = 8'h02,   // network controller
  parameter logic [7:0]  SUB_CLASS   = 8'h00,   // ethernet
  parameter logic [3:0]  REV_FIELD   = 4'h0,    // arbitrary value
  parameter logic [3:0]  STEP_FIELD  = 4'h1,    // arbitrary value
  parameter logic [15:0] PART_CODE   = 16'h5a5a, // arbitrary value
  parameter logic [15:0] MAKER_CODE  = 16'ha5a5  // arbitrary value
) (
  input  wire logic                          i_core_clk,
  input  wire logic                          i_srst,
  input  wire logic                          i_cfg_valid,
  input  wire pci_cfg_pkg::cfg_req_type      i_cfg_req,
  output logic [31:0]                        o_cfg_rdata,
  output logic                               o_cfg_ack,
  input  wire logic                          i_mem_space_en,
  input  wire logic                          i_frame_n,
  input  wire logic                          i_gnt_n,
  input  wire logic                          i_wake_event,
  input  wire logic                          i_power_resume,
  input  wire logic [1:0]                    i_cmd_wake_bits,
  input  wire logic                          i_eeprom_valid,
  input  wire pci_cfg_pkg::eeprom_image_type i_eeprom_image,
  output logic                               o_eeprom_load_req,
  output logic [23:0]                        o_io_window_addr,
  output logic [21:0]                        o_mem_window_addr,
  output logic [14:0]                        o_rom_window_addr,
  output logic                               o_rom_decode_on,
  output logic [7:0]                         o_line_size_dw,
  output logic [1:0]                         o_power_state_field,
  output logic                               o_pme_oe,
  output logic                               o_tenure_end,
  output logic                               o_wake_pkt_default
);

  // the whole state of the bank
  typedef struct packed {
    logic [7:0]                    line_size_dw;
    logic [7:0]                    bus_tenure_limit;
    logic [23:0]                   io_window_addr;
    logic [21:0]                   mem_window_addr;
    logic [14:0]                   rom_window_addr;
    logic                          rom_enable;
    logic [7:0]                    irq_line_route;
    logic [7:0]                    driver_scratch_byte;
    logic                          wake_status;
    logic                          wake_assert_enable;
    logic [3:0]                    data_report_select;
    logic [1:0]                    power_state_field;
    pci_cfg_pkg::eeprom_image_type image;
    pci_cfg_pkg::load_state_type   load_st;
    logic                          load_req;
    logic [31:0]                   rdata;
    logic                          ack;
    logic                          frame_s1;
    logic                          frame_s2;
    logic                          gnt_s1;
    logic                          gnt_s2;
    logic                          frame_prev;
    logic [7:0]                    tenure_cnt;
    logic                          tenure_run;
    logic                          tenure_end;
    logic                          pme_oe;
    logic                          wake_default;
    logic                          rom_decode;
  } regs_state_type;

  regs_state_type state_q;
  regs_state_type state_d;

  // byte-enable merge limited to the writable bits of a register
  function automatic logic [31:0] merge(input logic [31:0] old_w,
                                        input logic [31:0] new_w,
                                        input logic [3:0]  be,
                                        input logic [31:0] wmask);
    logic [31:0] m;
    m = wmask & {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    return (old_w & ~m) | (new_w & m);
  endfunction : merge

  // next-state logic: config access, wake, tenure timer, eeprom reload
  always_comb
  begin
    logic        wr;
    logic        rd;
    logic [31:0] lat_w;
    logic [31:0] io_w;
    logic [31:0] mem_w;
    logic [31:0] rom_w;
    logic [31:0] irq_w;
    logic [31:0] scr_w;
    logic [31:0] pmcsr_w;
    logic [31:0] mw;
    logic [31:0] rword;
    logic        wake_clr;
    logic        frame_start;
    state_d  = state_q;
    wr       = i_cfg_valid & i_cfg_req.wr;
    rd       = i_cfg_valid & ~i_cfg_req.wr;
    wake_clr = 1'b0;
    mw       = 32'h0000_0000;
    rword    = 32'h0000_0000;
    frame_start = state_q.frame_s2 & ~state_q.frame_prev;
    lat_w    = {16'h0000, state_q.bus_tenure_limit, state_q.line_size_dw};
    io_w     = {state_q.io_window_addr, 8'h01};
    mem_w    = {state_q.mem_window_addr, 10'h000};
    rom_w    = {state_q.rom_window_addr, 16'h0000,
                state_q.rom_enable};
    irq_w    = {state_q.image.max_latency_need,
                state_q.image.min_grant_need,
                pci_cfg_pkg::IRQ_PIN_CODE, state_q.irq_line_route};
    scr_w    = {16'h0000, state_q.driver_scratch_byte, 8'h00};
    pmcsr_w  = {16'h0000, state_q.wake_status,
                pci_cfg_pkg::DATA_SCALE_NONE,
                state_q.data_report_select, state_q.wake_assert_enable,
                6'h00, state_q.power_state_field};

    // pin synchronisers: first stage feeds only the second
    state_d.frame_s1   = ~i_frame_n;
    state_d.frame_s2   = state_q.frame_s1;
    state_d.gnt_s1     = ~i_gnt_n;
    state_d.gnt_s2     = state_q.gnt_s1;
    state_d.frame_prev = state_q.frame_s2;

    // configuration writes; read-only words take no decode here
    if (wr && i_cfg_req.addr[7:2] == pci_cfg_pkg::OFS_LAT[7:2])
    begin
      mw = merge(lat_w, i_cfg_req.wdata, i_cfg_req.be,
                 pci_cfg_pkg::LAT_WR_MASK);
      state_d.bus_tenure_limit = mw[15:8];
      state_d.line_size_dw     = mw[7:0];
    end
    else if (wr && i_cfg_req.addr[7:2] == pci_cfg_pkg::OFS_IO[7:2])
    begin
      mw = merge(io_w, i_cfg_req.wdata, i_cfg_req.be,
                 pci_cfg_pkg::IO_WR_MASK);
      state_d.io_window_addr = mw[31:pci_cfg_pkg::IO_ADDR_LSB];
    end
    else if (wr && i_cfg_req.addr[7:2] == pci_cfg_pkg::OFS_MEM[7:2])
    begin
      mw = merge(mem_w, i_cfg_req.wdata, i_cfg_req.be,
                 pci_cfg_pkg::MEM_WR_MASK);
      state_d.mem_window_addr = mw[31:pci_cfg_pkg::MEM_ADDR_LSB];
    end
    else if (wr && i_cfg_req.addr[7:2] == pci_cfg_pkg::OFS_ROM[7:2])
    begin
      mw = merge(rom_w, i_cfg_req.wdata, i_cfg_req.be,
                 pci_cfg_pkg::ROM_WR_MASK);
      state_d.rom_window_addr = mw[31:pci_cfg_pkg::ROM_ADDR_LSB];
      state_d.rom_enable      = mw[0];
    end
    else if (wr && i_cfg_req.addr[7:2] == pci_cfg_pkg::OFS_IRQ[7:2])
    begin
      mw = merge(irq_w, i_cfg_req.wdata, i_cfg_req.be,
                 pci_cfg_pkg::IRQ_WR_MASK);
      state_d.irq_line_route = mw[7:0];
    end
    else if (wr && i_cfg_req.addr[7:2] == pci_cfg_pkg::OFS_SCRATCH[7:2])
    begin
      mw = merge(scr_w, i_cfg_req.wdata, i_cfg_req.be,
                 pci_cfg_pkg::SCRATCH_WR_MASK);
      state_d.driver_scratch_byte = mw[15:8];
    end
    else if (wr && i_cfg_req.addr[7:2] == pci_cfg_pkg::OFS_PMCSR[7:2])
    begin
      mw = merge(pmcsr_w, i_cfg_req.wdata, i_cfg_req.be,
                 pci_cfg_pkg::PMCSR_WR_MASK);
      state_d.data_report_select = mw[12:pci_cfg_pkg::DATA_REPORT_SELECT_LSB];
      state_d.wake_assert_enable = mw[pci_cfg_pkg::WAKE_EN_BIT];
      state_d.power_state_field  = mw[1:0];
      wake_clr = i_cfg_req.be[1] &
                 i_cfg_req.wdata[pci_cfg_pkg::WAKE_STATUS_BIT];
    end

    // read decode; unmapped and reserved words read zero
    if (i_cfg_req.addr[7:2] == pci_cfg_pkg::OFS_CLASS[7:2])
      rword = {BASE_CLASS, SUB_CLASS, 8'h00,
               REV_FIELD, STEP_FIELD};
    else if (i_cfg_req.addr[7:2] == pci_cfg_pkg::OFS_LAT[7:2])
      rword = lat_w;
    else if (i_cfg_req.addr[7:2] == pci_cfg_pkg::OFS_IO[7:2])
      rword = io_w;
    else if (i_cfg_req.addr[7:2] == pci_cfg_pkg::OFS_MEM[7:2])
      rword = mem_w;
    else if (i_cfg_req.addr[7:2] == pci_cfg_pkg::OFS_CIS[7:2])
      rword = state_q.image.card_info;
    else if (i_cfg_req.addr[7:2] == pci_cfg_pkg::OFS_SUBSYS[7:2])
      rword = {state_q.image.subsys_id_field,
               state_q.image.subsys_vendor_field};
    else if (i_cfg_req.addr[7:2] == pci_cfg_pkg::OFS_ROM[7:2])
      rword = rom_w;
    else if (i_cfg_req.addr[7:2] == pci_cfg_pkg::OFS_CAPHEAD[7:2])
      rword = {24'h00_0000, pci_cfg_pkg::CAP_HEAD_PTR};
    else if (i_cfg_req.addr[7:2] == pci_cfg_pkg::OFS_IRQ[7:2])
      rword = irq_w;
    else if (i_cfg_req.addr[7:2] == pci_cfg_pkg::OFS_SCRATCH[7:2])
      rword = scr_w;
    else if (i_cfg_req.addr[7:2] == pci_cfg_pkg::OFS_SIG[7:2])
      rword = {PART_CODE, MAKER_CODE};
    else if (i_cfg_req.addr[7:2] == pci_cfg_pkg::OFS_PMCAP[7:2])
      rword = pci_cfg_pkg::PM_CAP_WORD;
    else if (i_cfg_req.addr[7:2] == pci_cfg_pkg::OFS_PMCSR[7:2])
      rword = pmcsr_w;
    else
      rword = 32'h0000_0000;
    if (rd)
      state_d.rdata = rword;
    state_d.ack = i_cfg_valid;

    // wake status: a new event beats a same-cycle clear
    state_d.wake_status = i_wake_event |
                          (state_q.wake_status & ~wake_clr);
    state_d.pme_oe = state_d.wake_status &
                     state_d.wake_assert_enable;
    // power resume overrides any write in the same cycle
    if (i_power_resume)
      state_d.power_state_field = pci_cfg_pkg::PSTATE_D0;
    state_d.wake_default = &i_cmd_wake_bits;
    state_d.rom_decode = state_q.rom_enable &
                         i_mem_space_en;

    // tenure timer, counting core clocks from the start of frame
    if (frame_start)
    begin
      state_d.tenure_cnt = state_q.bus_tenure_limit;
      state_d.tenure_run = 1'b1;
    end
    else if (!state_q.frame_s2)
      state_d.tenure_run = 1'b0;
    else if (state_q.tenure_run && state_q.tenure_cnt != 8'h00)
      state_d.tenure_cnt = state_q.tenure_cnt - 8'h01;
    state_d.tenure_end = state_q.tenure_run &
                         (state_q.tenure_cnt == 8'h00) &
                         state_q.frame_s2 & ~state_q.gnt_s2;

    // eeprom reload once after every pci reset
    case (state_q.load_st)
      pci_cfg_pkg::LD_REQ:
      begin
        state_d.load_st  = pci_cfg_pkg::LD_WAIT;
        state_d.load_req = 1'b0;
      end
      pci_cfg_pkg::LD_WAIT:
      begin
        if (i_eeprom_valid)
        begin
          state_d.image   = i_eeprom_image;
          state_d.load_st = pci_cfg_pkg::LD_IDLE;
        end
      end
      default:
      begin
        state_d.load_st = pci_cfg_pkg::LD_IDLE;
      end
    endcase
  end

  // state register; hardware reset clears everything including scratch, but raises the eeprom reload request
  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
    begin
      state_q                <= '0;
      state_q.io_window_addr <= pci_cfg_pkg::IO_RESET[31:8];
      state_q.load_st        <= pci_cfg_pkg::LD_REQ;
      state_q.load_req       <= 1'b1;
    end
    else
      state_q <= state_d;
  end

  // outputs straight from flops
  assign o_cfg_rdata         = state_q.rdata;
  assign o_cfg_ack           = state_q.ack;
  assign o_eeprom_load_req   = state_q.load_req;
  assign o_io_window_addr    = state_q.io_window_addr;
  assign o_mem_window_addr   = state_q.mem_window_addr;
  assign o_rom_window_addr   = state_q.rom_window_addr;
  assign o_rom_decode_on     = state_q.rom_decode;
  assign o_line_size_dw      = state_q.line_size_dw;
  assign o_power_state_field = state_q.power_state_field;
  assign o_pme_oe            = state_q.pme_oe;
  assign o_tenure_end        = state_q.tenure_end;
  assign o_wake_pkt_default  = state_q.wake_default;

  // checks
  sequence s_rom_all_ones;
    i_cfg_valid && i_cfg_req.wr && i_cfg_req.addr == pci_cfg_pkg::OFS_ROM &&
    i_cfg_req.be == 4'hf && i_cfg_req.wdata == 32'hffff_ffff;
  endsequence

  sequence s_rom_read;
    i_cfg_valid && !i_cfg_req.wr && i_cfg_req.addr == pci_cfg_pkg::OFS_ROM;
  endsequence

  property p_rom_readback;
    @(posedge i_core_clk) disable iff (i_srst)
      s_rom_all_ones ##1 !i_cfg_valid ##1 s_rom_read
      |=> o_cfg_rdata == 32'hfffe_0001;
  endproperty
  a_rom_readback: assert property (p_rom_readback)
    else $error("rom base readback wrong");

  property p_io_read;
    @(posedge i_core_clk) disable iff (i_srst)
      i_cfg_valid && !i_cfg_req.wr && i_cfg_req.addr == pci_cfg_pkg::OFS_IO
      |=> o_cfg_ack && o_cfg_rdata[7:0] == 8'h01;
  endproperty
  a_io_read: assert property (p_io_read)
    else $error("io base low byte wrong");

  property p_irq_pin;
    @(posedge i_core_clk) disable iff (i_srst)
      i_cfg_valid && !i_cfg_req.wr && i_cfg_req.addr == pci_cfg_pkg::OFS_IRQ
      |=> o_cfg_rdata[15:8] == 8'h01;
  endproperty
  a_irq_pin: assert property (p_irq_pin)
    else $error("interrupt pin not 01h");

  // an event always leaves status set, even against a same-cycle clear
  property p_wake_set_wins;
    @(posedge i_core_clk) disable iff (i_srst)
      i_wake_event |=> state_q.wake_status &&
                       o_pme_oe == state_q.wake_assert_enable;
  endproperty
  a_wake_set_wins: assert property (p_wake_set_wins)
    else $error("wake event lost");

  property p_pme_gated;
    @(posedge i_core_clk) disable iff (i_srst)
      o_pme_oe |-> $past(state_d.wake_assert_enable) && state_q.wake_status;
  endproperty
  a_pme_gated: assert property (p_pme_gated)
    else $error("wake pin driven while disabled");

  property p_resume_d0;
    @(posedge i_core_clk) disable iff (i_srst)
      i_power_resume |=> o_power_state_field == 2'b00;
  endproperty
  a_resume_d0: assert property (p_resume_d0)
    else $error("power state not back to d0");

  property p_rom_decode;
    @(posedge i_core_clk) disable iff (i_srst)
      o_rom_decode_on |-> $past(i_mem_space_en) && $past(state_q.rom_enable);
  endproperty
  a_rom_decode: assert property (p_rom_decode)
    else $error("rom decoded without both enables");

  property p_wake_default;
    @(posedge i_core_clk) disable iff (i_srst)
      i_cmd_wake_bits == 2'b11 |=> o_wake_pkt_default;
  endproperty
  a_wake_default: assert property (p_wake_default)
    else $error("wake packet default not set");

  property p_tenure_end;
    @(posedge i_core_clk) disable iff (i_srst)
      o_tenure_end |-> $past(state_q.frame_s2) && !$past(state_q.gnt_s2);
  endproperty
  a_tenure_end: assert property (p_tenure_end)
    else $error("tenure ended without frame or with grant");

  property p_reload_req;
    @(posedge i_core_clk)
      $fell(i_srst) |-> o_eeprom_load_req ##1 !o_eeprom_load_req;
  endproperty
  a_reload_req: assert property (p_reload_req)
    else $error("no eeprom reload after reset");

endmodule : pci_config_space_regs

`default_nettype wire

// >>> pci_config_space_regs_tb.sv
// self-checking bench for the configuration register bank
// assumes cfg_host_model as the host and a 25 MHz core clock
`timescale 1ns/1ps
`default_nettype none
module pci_config_space_regs_tb;
  logic clk = 1'b0, srst = 1'b1, mem_en = 1'b0, frame_n = 1'b1;
  logic gnt_n = 1'b0, wake_ev = 1'b0, resume = 1'b0, ee_valid = 1'b0;
  logic [1:0] cmd_wake = 2'b00;
  pci_cfg_pkg::eeprom_image_type ee_img =
    {16'h1111, 16'h2222, 8'h33, 8'h44, 32'h5555_6666};
  pci_cfg_pkg::cfg_req_type req;
  logic valid, ack, load_req, rom_on, pme_oe, ten_end, pkt_def;
  logic [31:0] rdata;
  logic [23:0] io_addr;
  logic [21:0] mem_addr;
  logic [14:0] rom_addr;
  logic [7:0]  line_size;
  logic [1:0]  pstate;
  int fail_count = 0;
  int n_checks = 0;

  always #20 clk = ~clk;

  // identity parameters are arbitrary values
  pci_config_space_regs #(.REV_FIELD(4'h2), .STEP_FIELD(4'h3),
    .PART_CODE(16'h3c3c), .MAKER_CODE(16'hc3c3)) DUT (
    .i_core_clk(clk), .i_srst(srst), .i_cfg_valid(valid),
    .i_cfg_req(req), .o_cfg_rdata(rdata), .o_cfg_ack(ack),
    .i_mem_space_en(mem_en), .i_frame_n(frame_n), .i_gnt_n(gnt_n),
    .i_wake_event(wake_ev), .i_power_resume(resume),
    .i_cmd_wake_bits(cmd_wake), .i_eeprom_valid(ee_valid),
    .i_eeprom_image(ee_img), .o_eeprom_load_req(load_req),
    .o_io_window_addr(io_addr), .o_mem_window_addr(mem_addr),
    .o_rom_window_addr(rom_addr), .o_rom_decode_on(rom_on),
    .o_line_size_dw(line_size), .o_power_state_field(pstate),
    .o_pme_oe(pme_oe), .o_tenure_end(ten_end),
    .o_wake_pkt_default(pkt_def));

  cfg_host_model H (.i_core_clk(clk), .i_ack(ack), .i_rdata(rdata),
    .o_valid(valid), .o_req(req));

  task automatic chk(input string n, input logic [31:0] e, g);
    n_checks++;
    if (e !== g)
    begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic stop_test;
    if (fail_count == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : stop_test

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    H.access(1'b0, a, 4'h0, 32'h0000_0000);
    chk("read ack", 32'h0000_0001, 32'(H.ack_seen));
    chk("read word", e, H.rd_q);
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [3:0] be,
                    input logic [31:0] d);
    H.access(1'b1, a, be, d);
    chk("write ack", 32'h0000_0001, 32'(H.ack_seen));
  endtask : wr

  // reset value, then all ones written, then read back
  task automatic rw_one(input logic [7:0] a, input logic [31:0] r, w);
    rd(a, r);
    wr(a, 4'hf, 32'hffff_ffff);
    rd(a, w);
  endtask : rw_one

  task automatic t_regs;
    rw_one(8'h08, 32'h0200_0023, 32'h0200_0023);
    rw_one(8'h0c, 32'h0000_0000, 32'h0000_ffff);
    rw_one(8'h10, 32'h0000_0001, 32'hffff_ff01);
    rw_one(8'h14, 32'h0000_0000, 32'hffff_fc00);
    rw_one(8'h28, 32'h5555_6666, 32'h5555_6666);
    rw_one(8'h2c, 32'h1111_2222, 32'h1111_2222);
    rw_one(8'h30, 32'h0000_0000, 32'hfffe_0001);
    rw_one(8'h34, 32'h0000_00c0, 32'h0000_00c0);
    rw_one(8'h3c, 32'h3344_0100, 32'h3344_01ff);
    rw_one(8'h40, 32'h0000_0000, 32'h0000_ff00);
    rw_one(8'h80, 32'h3c3c_c3c3, 32'h3c3c_c3c3);
    rw_one(8'hc0, 32'hfe82_0001, 32'hfe82_0001);
    rw_one(8'hc4, 32'h0000_0000, 32'h0000_1f03);
    rw_one(8'h20, 32'h0000_0000, 32'h0000_0000);
    chk("io window", 32'h00ff_ffff, 32'(io_addr));
    chk("mem window", 32'h003f_ffff, 32'(mem_addr));
    wr(8'h0c, 4'h1, 32'hffff_ff08);
    rd(8'h0c, 32'h0000_ff08);
    chk("line size", 32'h0000_0008, 32'(line_size));
    wr(8'h3c, 4'h1, 32'h0000_0005);
    rd(8'h3c, 32'h3344_0105);
  endtask : t_regs

  // decode needs both rom enable and memory space enable
  task automatic t_rom;
    repeat (2) @(posedge clk);
    #1 chk("rom off", 32'h0, 32'(rom_on));
    mem_en <= 1'b1;
    repeat (2) @(posedge clk);
    #1 chk("rom on", 32'h1, 32'(rom_on));
    chk("rom addr", 32'h0000_7fff, 32'(rom_addr));
    wr(8'h30, 4'hf, 32'hfffe_0000);
    @(posedge clk);
    #1 chk("rom off", 32'h0, 32'(rom_on));
  endtask : t_rom

  task automatic pulse_wake;
    @(posedge clk) wake_ev <= 1'b1;
    @(posedge clk) wake_ev <= 1'b0;
    #1;
  endtask : pulse_wake

  // status latches, pin follows enable, write one clears
  task automatic t_wake;
    chk("pstate", 32'h3, 32'(pstate));
    pulse_wake;
    chk("pme on", 32'h1, 32'(pme_oe));
    rd(8'hc4, 32'h0000_9f03);
    wr(8'hc4, 4'h2, 32'h0000_8000);
    rd(8'hc4, 32'h0000_0003);
    pulse_wake;
    chk("pme masked", 32'h0, 32'(pme_oe));
    rd(8'hc4, 32'h0000_8003);
    // event held across a clearing write: the set must win
    wake_ev <= 1'b1;
    wr(8'hc4, 4'h2, 32'h0000_8000);
    wake_ev <= 1'b0;
    rd(8'hc4, 32'h0000_8003);
    @(posedge clk) resume <= 1'b1;
    @(posedge clk) resume <= 1'b0;
    #1 chk("pstate d0", 32'h0, 32'(pstate));
  endtask : t_wake

  // latency 4 counted from frame, ends once grant is gone
  task automatic t_tenure;
    int k;
    wr(8'h0c, 4'h2, 32'h0000_0400);
    @(posedge clk)
    begin
      frame_n <= 1'b0;
      gnt_n   <= 1'b1;
    end
    repeat (3) @(posedge clk);
    #1 chk("tenure early", 32'h0, 32'(ten_end));
    for (k = 0; k < 20 && ten_end !== 1'b1; k++)
      @(posedge clk) #1;
    chk("tenure end", 32'h1, 32'(ten_end));
    frame_n <= 1'b1;
    cmd_wake <= 2'b11;
    repeat (2) @(posedge clk);
    #1 chk("pkt default", 32'h1, 32'(pkt_def));
    cmd_wake <= 2'b01;
    repeat (2) @(posedge clk);
    #1 chk("pkt off", 32'h0, 32'(pkt_def));
  endtask : t_tenure

  initial
  begin
    #200us;
    fail_count++;
    stop_test;
  end

  // reset, eeprom image delivery, then the scenarios
  initial
  begin
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    repeat (2) @(posedge clk);
    ee_valid <= 1'b1;
    @(posedge clk) ee_valid <= 1'b0;
    #1 chk("load req", 32'h0, 32'(load_req));
    t_regs;
    t_rom;
    t_wake;
    t_tenure;
    stop_test;
  end
endmodule : pci_config_space_regs_tb
`default_nettype wire
